// ---- design/timer_event_consts.vh ----
// Purpose: Named constants for the event-counter timer channel
// Assumes: APB with 32-bit data, one register per aligned word
// Notes: Offsets are byte addresses
`ifndef TIMER_EVENT_CONSTS_VH
`define TIMER_EVENT_CONSTS_VH

// ----------------------------------------
// Register map
// ----------------------------------------
`define ADDR_COUNT 8'h00
`define ADDR_MODE 8'h04
`define ADDR_CTRL 8'h08
`define ADDR_STATUS 8'h0C

// ----------------------------------------
// Mode register fields
// ----------------------------------------
`define MODE_SEL_LO 0
`define MODE_SEL_HI 1
`define MODE_EVENT 2'h1
`define MODE_PULSE_EN 2
`define MODE_DIR_FROM_PIN 3
`define MODE_SW_UP 4
`define MODE_FREE_RUN 5
`define MODE_RISING_EDGE 6
`define MODE_TWO_PHASE 7
`define MODE_X4 8
`define MODE_SRC_LO 9
`define MODE_SRC_HI 10
`define MODE_WIDTH 11
`define MODE_RESET 11'h000

// ----------------------------------------
// Event sources and other fields
// ----------------------------------------
`define SRC_PIN 2'h0
`define SRC_PEER_B2 2'h1
`define SRC_SIBLING_A 2'h2
`define CTRL_START 0
`define STAT_PIN_LEVEL 0
`define STAT_DIR_UP 1
`define STAT_RUNNING 2
`define CNT_WIDTH 16
`define CNT_MAX 16'hFFFF
`define CNT_ZERO 16'h0000
`define CNT_ONE 16'h0001
`define CNT_RESET 16'h0000
`define RDATA_ZERO 32'h00000000

`endif

// ---- design/timer_event_counter.v ----
// Purpose: One 16-bit timer channel in event-counter mode, APB registers
// Assumes: Pin inputs are asynchronous; overflow inputs are clk-domain pulses
// Notes: CHANNEL selects pin presence and two-phase capability
//
// The implementer's own choices: the APB slave port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
`include "timer_event_consts.vh"

// ----------------------------------------
// Two-flop synchroniser
// ----------------------------------------
module sync_two_flop (
	input wire clk, // System clock
	input wire sys_rst, // Async reset, active high
	input wire async_i, // Asynchronous level
	output wire sync_o // Synchronised level
);
	reg meta_q;
	reg sync_q;

	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
		end else begin
			meta_q <= async_i;
			sync_q <= meta_q;
		end
	end

	// Only the second flop is read; the first may still be settling
	assign sync_o = sync_q;
endmodule

// ----------------------------------------
// Edge detector on a synchronised level
// ----------------------------------------
module edge_detect (
	input wire clk, // System clock
	input wire sys_rst, // Async reset, active high
	input wire level_i, // Synchronised level
	output wire rise_o, // Level went high
	output wire fall_o, // Level went low
	output wire prev_o // Level one cycle ago
);
	// Resets low, the idle level of the synchroniser, so no false edge
	reg prev_q;

	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			prev_q <= 1'b0;
		end else begin
			prev_q <= level_i;
		end
	end

	assign rise_o = level_i & ~prev_q;
	assign fall_o = ~level_i & prev_q;
	assign prev_o = prev_q;
endmodule

// ----------------------------------------
// Channel top
// ----------------------------------------
module timer_event_counter #(
	parameter CHANNEL = 3
) (
	input wire clk, // System clock, 10 MHz
	input wire sys_rst, // Async reset, active high
	input wire psel, // APB select
	input wire penable, // APB access phase
	input wire pwrite, // APB write
	input wire [7:0] paddr, // APB byte address
	input wire [31:0] pwdata, // APB write data
	output wire pready, // APB ready
	output reg [31:0] prdata, // APB read data
	output wire pslverr, // APB error on unmapped address
	input wire count_input_pin_i, // Count input pin level
	input wire auxiliary_timer_pin_i, // Auxiliary pin level
	output wire auxiliary_timer_pin_o, // Auxiliary pin drive level
	output wire auxiliary_timer_pin_oe, // Auxiliary pin drive enable
	input wire peer_b_timer_two_ovf, // Peer B2 overflow pulse
	input wire sibling_a_channel_ovf, // Sibling A overflow pulse
	output wire irq_req // Overflow/underflow request pulse
);
	localparam HAS_PINS = (CHANNEL != 1) && (CHANNEL != 2);
	localparam HAS_QUAD = (CHANNEL >= 2);
	localparam HAS_NORMAL = (CHANNEL == 2) || (CHANNEL == 3);
	localparam HAS_CHOICE = (CHANNEL == 3);

	reg [`CNT_WIDTH-1:0] count_q;
	reg [`CNT_WIDTH-1:0] count_d;
	reg [`CNT_WIDTH-1:0] reload_q;
	reg [`CNT_WIDTH-1:0] reload_d;
	reg [`MODE_WIDTH-1:0] mode_q;
	reg start_q;
	reg pulse_q;
	reg pulse_d;
	reg irq_q;
	reg irq_d;

	wire in_sync;
	wire aux_sync;
	wire in_lvl;
	wire aux_lvl;
	wire aux_prev;
	wire acc;
	wire wr;
	wire rd;
	wire mapped;
	wire two_phase;
	wire use_x4;
	wire running;
	wire dir_up_sw;
	wire in_rise;
	wire in_fall;
	wire aux_rise;
	wire aux_fall;
	wire [1:0] src;
	reg step;
	reg up;
	wire wrap;

	// ----------------------------------------
	// Pin synchronisation
	// ----------------------------------------
	// sync inputs
	sync_two_flop u_sync_in (
		.clk(clk),
		.sys_rst(sys_rst),
		.async_i(count_input_pin_i),
		.sync_o(in_sync)
	);

	sync_two_flop u_sync_aux (
		.clk(clk),
		.sys_rst(sys_rst),
		.async_i(auxiliary_timer_pin_i),
		.sync_o(aux_sync)
	);

	// Absent pins read low so no event leaks in
	assign in_lvl = HAS_PINS ? in_sync : 1'b0;
	assign aux_lvl = HAS_PINS ? aux_sync : 1'b0;

	edge_detect u_edge_in (
		.clk(clk),
		.sys_rst(sys_rst),
		.level_i(in_lvl),
		.rise_o(in_rise),
		.fall_o(in_fall),
		.prev_o()
	);

	edge_detect u_edge_aux (
		.clk(clk),
		.sys_rst(sys_rst),
		.level_i(aux_lvl),
		.rise_o(aux_rise),
		.fall_o(aux_fall),
		.prev_o(aux_prev)
	);

	// ----------------------------------------
	// Mode decode
	// ----------------------------------------
	// event mode pattern, start flag
	assign running = start_q &&
		(mode_q[`MODE_SEL_HI:`MODE_SEL_LO] == `MODE_EVENT);
	assign two_phase = HAS_QUAD && mode_q[`MODE_TWO_PHASE];
	assign use_x4 = HAS_CHOICE ? mode_q[`MODE_X4] : !HAS_NORMAL;
	assign src = mode_q[`MODE_SRC_HI:`MODE_SRC_LO];
	assign dir_up_sw = mode_q[`MODE_DIR_FROM_PIN] ? aux_lvl : mode_q[`MODE_SW_UP];

	// ----------------------------------------
	// Event and direction selection
	// ----------------------------------------
	always @* begin
		step = 1'b0;
		up = dir_up_sw;
		if (two_phase) begin
			if (use_x4) begin
				// all edges, phase gives direction
				// Both pins moving in one sample is ambiguous and dropped
				step = (in_rise | in_fall) ^ (aux_rise | aux_fall);
				up = ~(in_lvl ^ aux_prev);
			end else begin
				step = aux_lvl & (in_rise | in_fall);
				up = in_rise;
			end
		end else begin
			case (src)
				`SRC_PIN: begin
					step = mode_q[`MODE_RISING_EDGE] ? in_rise : in_fall;
				end
				`SRC_PEER_B2: begin
					step = peer_b_timer_two_ovf;
				end
				`SRC_SIBLING_A: begin
					step = sibling_a_channel_ovf;
				end
				default: begin
					step = 1'b0;
				end
			endcase
		end
	end

	// ----------------------------------------
	// APB access
	// ----------------------------------------
	// Zero wait states: every access completes in its first access cycle
	assign pready = 1'b1;
	assign acc = psel & penable;
	assign wr = acc & pwrite;
	assign rd = acc & ~pwrite;
	assign mapped = (paddr == `ADDR_COUNT) || (paddr == `ADDR_MODE) ||
		(paddr == `ADDR_CTRL) || (paddr == `ADDR_STATUS);
	assign pslverr = acc & ~mapped;

	// ----------------------------------------
	// Counter, reload, pulse output
	// ----------------------------------------
	// Judged on the old count, so reload and request share one edge
	// limit reached on this step
	assign wrap = running & step & (up ? (count_q == `CNT_MAX) : (count_q == `CNT_ZERO));

	always @* begin
		count_d = count_q;
		reload_d = reload_q;
		pulse_d = pulse_q;
		irq_d = 1'b0;
		if (running && step) begin
			if (wrap && !mode_q[`MODE_FREE_RUN]) begin
				count_d = reload_q;
			end else if (up) begin
				count_d = count_q + `CNT_ONE;
			end else begin
				count_d = count_q - `CNT_ONE;
			end
		end
		if (wrap) begin
			irq_d = 1'b1;
			if (mode_q[`MODE_PULSE_EN]) begin
				pulse_d = ~pulse_q;
			end
		end
		// A running write leaves the counter to the counting step
		if (wr && paddr == `ADDR_COUNT) begin
			reload_d = pwdata[`CNT_WIDTH-1:0];
			if (!running) begin
				count_d = pwdata[`CNT_WIDTH-1:0];
			end
		end
	end

	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			count_q <= `CNT_RESET;
			reload_q <= `CNT_RESET;
			pulse_q <= 1'b0;
			irq_q <= 1'b0;
		end else begin
			count_q <= count_d;
			reload_q <= reload_d;
			pulse_q <= pulse_d;
			irq_q <= irq_d;
		end
	end

	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			mode_q <= `MODE_RESET;
			start_q <= 1'b0;
		end else begin
			// Mode writes act at once, even while counting
			if (wr && paddr == `ADDR_MODE) begin
				mode_q <= pwdata[`MODE_WIDTH-1:0];
			end
			if (wr && paddr == `ADDR_CTRL) begin
				start_q <= pwdata[`CTRL_START];
			end
		end
	end

	assign irq_req = irq_q;

	// ----------------------------------------
	// Pin ownership
	// ----------------------------------------
	// auxiliary pin drives only as pulse output
	assign auxiliary_timer_pin_oe = HAS_PINS && mode_q[`MODE_PULSE_EN] &&
		!mode_q[`MODE_DIR_FROM_PIN] && !two_phase;
	assign auxiliary_timer_pin_o = pulse_q;

	// ----------------------------------------
	// Read data
	// ----------------------------------------
	// Captured in setup so data stands through the access phase
	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			prdata <= `RDATA_ZERO;
		end else if (psel && !penable && !pwrite) begin
			prdata <= `RDATA_ZERO;
			case (paddr)
				`ADDR_COUNT: begin
					prdata[`CNT_WIDTH-1:0] <= count_q;
				end
				`ADDR_MODE: begin
					prdata[`MODE_WIDTH-1:0] <= mode_q;
				end
				`ADDR_CTRL: begin
					prdata[`CTRL_START] <= start_q;
				end
				`ADDR_STATUS: begin
					prdata[`STAT_PIN_LEVEL] <= pulse_q;
					prdata[`STAT_DIR_UP] <= up;
					prdata[`STAT_RUNNING] <= running;
				end
				default: begin
					prdata <= `RDATA_ZERO;
				end
			endcase
		end
	end
endmodule
`default_nettype wire

// ---- verification/timer_event_props.sv ----
// Purpose: Port-level properties of the event-counter channel
// Assumes: Bound to timer_event_counter, single clock domain
// Notes: Pin-driven wraps are judged from recent input activity only
`timescale 1ns/10ps
`default_nettype none
module timer_event_props (
	input wire clk, // System clock
	input wire sys_rst, // Async reset
	input wire psel, // APB select
	input wire penable, // APB access
	input wire pwrite, // APB write
	input wire [7:0] paddr, // APB address
	input wire pready, // APB ready
	input wire [31:0] prdata, // APB read data
	input wire pslverr, // APB error
	input wire count_input_pin_i, // Count pin
	input wire auxiliary_timer_pin_i, // Aux pin in
	input wire auxiliary_timer_pin_o, // Aux pin out
	input wire auxiliary_timer_pin_oe, // Aux pin enable
	input wire peer_b_timer_two_ovf, // B2 overflow
	input wire sibling_a_channel_ovf, // Sibling overflow
	input wire irq_req // Wrap request
);
	// ----------------------------------------
	// Activity tracker
	// ----------------------------------------
	// Saturates so long idle spells never wrap back to zero
	reg [3:0] quiet_q;
	reg [1:0] pins_q;
	wire act = peer_b_timer_two_ovf | sibling_a_channel_ovf |
		(pins_q != {count_input_pin_i, auxiliary_timer_pin_i});
	wire [3:0] quiet_d = act ? 4'h0 : (quiet_q == 4'hF ? quiet_q : quiet_q + 4'h1);
	wire rd_acc = psel && penable && !pwrite;
	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			quiet_q <= 4'hF;
			pins_q <= 2'h0;
		end else begin
			quiet_q <= quiet_d;
			pins_q <= {count_input_pin_i, auxiliary_timer_pin_i};
		end
	end
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	default clocking dc @(posedge clk); endclocking
	default disable iff (sys_rst);
	a_ready_high: assert property (psel && penable |-> pready)
		else $error("access phase not ready");
	a_count_width: assert property (rd_acc && paddr == 8'h00 |-> prdata[31:16] == 16'h0000)
		else $error("count read wider than 16 bits");
	a_status_width: assert property (rd_acc && paddr == 8'h0C |-> prdata[31:3] == 29'h0)
		else $error("status unused bits set");
	a_unmapped_err: assert property (psel && penable && paddr > 8'h0C |-> pslverr)
		else $error("unmapped access not refused");
	a_err_data: assert property (rd_acc && pslverr |-> prdata == 32'h0)
		else $error("refused read returned data");
	a_read_stands: assert property (rd_acc |=> $stable(prdata))
		else $error("read data moved after access");
	a_irq_cause: assert property (irq_req |-> quiet_q < 4'h8)
		else $error("wrap request without event");
	a_wrap_toggle: assert property (irq_req && auxiliary_timer_pin_oe && $past(auxiliary_timer_pin_oe) |-> auxiliary_timer_pin_o != $past(auxiliary_timer_pin_o))
		else $error("pulse output missed a wrap");
	a_toggle_cause: assert property ($changed(auxiliary_timer_pin_o) |-> irq_req)
		else $error("pulse output moved without wrap");
	cover property (irq_req && auxiliary_timer_pin_oe);
	cover property (irq_req && !auxiliary_timer_pin_oe);
	cover property (pslverr);
endmodule
bind timer_event_counter timer_event_props u_props (.clk, .sys_rst, .psel, .penable, .pwrite,
	.paddr, .pready, .prdata, .pslverr, .count_input_pin_i, .auxiliary_timer_pin_i,
	.auxiliary_timer_pin_o, .auxiliary_timer_pin_oe, .peer_b_timer_two_ovf,
	.sibling_a_channel_ovf, .irq_req);
`default_nettype wire

// ---- verification/pulse_source.sv ----
// Purpose: External pulse source and two-phase encoder
// Assumes: Levels held well beyond the synchroniser depth
// Notes: Only one line moves per step
`timescale 1ns/10ps
`default_nettype none
module pulse_source (
	input wire logic clk, // System clock
	output logic count_pin, // Count input level
	output logic aux_pin // Auxiliary input level
);
	initial begin
		count_pin = 1'b0;
		aux_pin = 1'b0;
	end
	// drive-only lines, one edge a step
	task automatic toggle(input bit which);
		@(posedge clk);
		if (which) aux_pin <= ~aux_pin;
		else count_pin <= ~count_pin;
		repeat (6) @(posedge clk);
	endtask
endmodule
`default_nettype wire

// ---- verification/tb_top.sv ----
// Purpose: Self-checking bench for the event-counter channel
// Assumes: CHANNEL 3, so both two-phase processings are selectable
// Notes: Integer model follows every event and register write
`timescale 1ns/10ps
`default_nettype none
`include "timer_event_consts.vh"
module tb_top;
	logic clk = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, rdata;
	logic peer_ovf = 1'b0, sib_ovf = 1'b0, err;
	wire pready, pslverr, pin_o, pin_oe, irq, count_pin, src_aux;
	wire [31:0] prdata;
	wire aux_wire = pin_oe ? pin_o : src_aux;
	integer num_errors = 0, num_checks = 0, cyc = 0, irq_seen = 0, exp_irq = 0, seed = 64;
	integer cnt = 0, rld = 0, mode = 0, lvl = 0, run = 0, i, e;
	always #50 clk = ~clk;
	pulse_source src (.clk(clk), .count_pin(count_pin), .aux_pin(src_aux));
	timer_event_counter #(.CHANNEL(3)) dut (.clk(clk), .sys_rst(sys_rst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
		.prdata(prdata), .pslverr(pslverr), .count_input_pin_i(count_pin),
		.auxiliary_timer_pin_i(aux_wire), .auxiliary_timer_pin_o(pin_o),
		.auxiliary_timer_pin_oe(pin_oe), .peer_b_timer_two_ovf(peer_ovf),
		.sibling_a_channel_ovf(sib_ovf), .irq_req(irq));
	always @(posedge clk) begin
		cyc++;
		if (irq === 1'b1) irq_seen++;
		if (cyc == 20000) begin
			num_errors++;
			print_verdict;
		end
	end
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic print_verdict;
		$display("Checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic apb(input bit wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) @(posedge clk);
		rdata = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic step(input integer up);
		if (run) begin
			if (up ? cnt == 65535 : cnt == 0) begin
				cnt = mode[5] ? (up ? 0 : 65535) : rld;
				exp_irq++;
				if (mode[2]) lvl = !lvl;
			end else cnt = up ? cnt + 1 : cnt - 1;
		end
	endtask
	task automatic ovf(input bit b2);
		@(posedge clk);
		peer_ovf <= b2;
		sib_ovf <= !b2;
		@(posedge clk);
		peer_ovf <= 1'b0;
		sib_ovf <= 1'b0;
		if (mode[10:9] == (b2 ? 1 : 2)) step(mode[3] ? aux_wire : mode[4]);
	endtask
	task automatic move(input bit which);
		src.toggle(which);
		if (mode[7] && !mode[8]) begin
			if (!which && src_aux) step(count_pin);
		end else if (mode[7]) step(which ? src_aux != count_pin : count_pin == src_aux);
		else if (!which && count_pin == mode[6]) step(mode[3] ? src_aux : mode[4]);
	endtask
	task automatic wmode(input integer v);
		mode = v;
		apb(1, `ADDR_MODE, v);
	endtask
	task automatic start(input integer s);
		run = s;
		apb(1, `ADDR_CTRL, s);
	endtask
	task automatic wcount(input integer v);
		apb(1, `ADDR_COUNT, v);
		rld = v;
		if (!run) cnt = v;
	endtask
	task automatic verify;
		apb(0, `ADDR_COUNT, 0);
		check(rdata, cnt);
		check(irq_seen, exp_irq);
		check(pin_o, lvl);
		check(pin_oe, mode[2] && !mode[3] && !mode[7]);
		apb(0, `ADDR_STATUS, 0);
		check(rdata & 32'h5, {run != 0 && mode[1:0] == 1, 1'b0, lvl[0]});
	endtask
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		repeat (5) @(posedge clk);
		sys_rst <= 1'b0;
		for (i = 0; i < 4; i++) begin
			apb(0, 8'(i * 4), 0);
			check(rdata, 0);
		end
		apb(0, 8'h10, 0);
		check(err, 1);
		wcount(16'hFFFD);
		verify;
		wmode(`MODE_EVENT | 1 << `MODE_PULSE_EN | 1 << `MODE_SW_UP | `SRC_SIBLING_A << `MODE_SRC_LO);
		start(1);
		for (i = 0; i < 10; i++) ovf(i % 3 == 1);
		verify;
		wcount(16'hFFF0);
		verify;
		repeat (6) ovf(0);
		verify;
		start(0);
		repeat (3) ovf(0);
		verify;
		wcount(2);
		wmode(`MODE_EVENT | `SRC_PEER_B2 << `MODE_SRC_LO);
		start(1);
		for (i = 0; i < 8; i++) ovf(i % 4 != 3);
		verify;
		start(0);
		wcount(16'hFFFF);
		wmode(`MODE_EVENT | 1 << `MODE_FREE_RUN | 1 << `MODE_SW_UP | `SRC_SIBLING_A << `MODE_SRC_LO);
		start(1);
		repeat (2) ovf(0);
		verify;
		for (e = 0; e < 2; e++) begin
			wmode(`MODE_EVENT | 1 << `MODE_DIR_FROM_PIN | e << `MODE_RISING_EDGE);
			repeat (30) move($random(seed) & 1);
			verify;
		end
		for (e = 0; e < 2; e++) begin
			wmode(`MODE_EVENT | 1 << `MODE_TWO_PHASE | e << `MODE_X4);
			repeat (40) move($random(seed) & 1);
			verify;
		end
		print_verdict;
	end
endmodule
`default_nettype wire
